// ### rtl/gasr_pkg.sv
// Functional notes
// - Start generator after raw battery below 15-minute level for 15 minutes; quiet blocks.
// - Start generator after battery below 30-second level for 30 s, even in quiet.
// - 30-second level is read-only and always mirrors the low battery cutout level.
// - Count days against exercise period 0..255; start at end of quiet time.
// - Exercise run lasts a fixed 10 minutes.
// - Any 5-minute generator run restarts the exercise day count.
// - Period zero disables exercising; period one exercises every day.
// - During exercise, do not connect generator while utility power is present.
// - After maximum run time, flash error and flag advisory error; keep running.
// - Run time error clears only on mode off then auto or on; zero disables.
// - Run function: start relay energized whole time generator runs, off otherwise.
// - Glow/stop function: relay off while running, pulsed to stop.
// - Glow/stop function: relay also energized as glow before each crank.
// - Warm up 16..255 s (default 60) before connecting load and charger.
// - Pre-crank delay 0..255 s between start/glow relay and starter relay.
// - Starter relay energized at most crank limit 0..15 s per attempt.
// - Post-crank delay 0..255 s; retry start up to 5 attempts total.
// - Three independently configured auxiliary relays, independent of inverter state.
// - Auxiliary relay energizes when compensated voltage exceeds trip, within 0.1 s.
// - Energized relay releases at trip minus hysteresis, stays off until trip exceeded.
// - Auxiliary relay release path has a 2-second delay.
// - Hysteresis 0.1..12.8 V per relay, default 1.0 V.
package gasr_pkg;

  // Timebase
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned TENTHS_PER_SEC = 10;
  localparam int unsigned T15_MIN = 15;
  localparam int unsigned T30_SEC = 30;
  localparam int unsigned EXER_RUN_MIN = 10;
  localparam int unsigned EXER_QUAL_MIN = 5;
  localparam int unsigned AUX_REL_SEC = 2;
  localparam int unsigned STOP_PULSE_SEC = 3;
  localparam logic [9:0] T15_CNT = 10'(T15_MIN * 60);
  localparam logic [4:0] T30_CNT = 5'(T30_SEC);
  localparam logic [9:0] EXER_RUN_CNT = 10'(EXER_RUN_MIN * 60);
  localparam logic [8:0] EXER_QUAL_CNT = 9'(EXER_QUAL_MIN * 60);
  localparam logic [4:0] AUX_REL_CNT = 5'(AUX_REL_SEC * TENTHS_PER_SEC);
  localparam logic [7:0] STOP_PULSE_CNT = 8'(STOP_PULSE_SEC);
  localparam logic [3:0] TENTH_LAST = 4'(TENTHS_PER_SEC - 1);
  localparam logic [2:0] MAX_ATTEMPTS = 3'd5;
  localparam logic [5:0] SEC_LAST = 6'd59;

  // Register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_LVL15 = 8'h04;
  localparam logic [7:0] A_LOW_BATTERY_CUTOUT_LEVEL = 8'h08;
  localparam logic [7:0] A_LVL30 = 8'h0c;
  localparam logic [7:0] A_EXER = 8'h10;
  localparam logic [7:0] A_MAXRUN = 8'h14;
  localparam logic [7:0] A_WARMUP = 8'h18;
  localparam logic [7:0] A_PRECRANK = 8'h1c;
  localparam logic [7:0] A_CRANK = 8'h20;
  localparam logic [7:0] A_POSTCRANK = 8'h24;
  localparam logic [7:0] A_AUX_BASE = 8'h28;
  localparam logic [7:0] A_AUX_STRIDE = 8'h08;
  localparam logic [7:0] A_HYST_OFS = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h40;

  // Control fields and mode codes
  localparam int unsigned F_MODE = 0;
  localparam int unsigned F_QUIET = 2;
  localparam int unsigned F_GLOW = 3;
  localparam int unsigned F_RELEASE = 4;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] MODE_ON = 2'h2;

  // Reset values and limits, voltages in 0.1 V steps
  localparam logic [1:0] MODE_RST = MODE_OFF;
  localparam logic [11:0] LVL15_RST = 12'h071;
  localparam logic [11:0] LOW_BATTERY_CUTOUT_LEVEL_RST = 12'h06e;
  localparam logic [7:0] EXER_RST = 8'h1e;
  localparam logic [10:0] MAXRUN_RST = 11'h1e0;
  localparam logic [10:0] MAXRUN_MAX = 11'h596;
  localparam logic [7:0] WARMUP_RST = 8'h3c;
  localparam logic [7:0] WARMUP_MIN = 8'h10;
  localparam logic [7:0] PRECRANK_RST = 8'h0a;
  localparam logic [3:0] CRANK_RST = 4'ha;
  localparam logic [7:0] POSTCRANK_RST = 8'h1e;
  localparam logic [2:0][11:0] TRIP_RST = {12'h096, 12'h094, 12'h091};
  localparam logic [7:0] HYST_RST = 8'h0a;
  localparam logic [7:0] HYST_MIN = 8'h01;
  localparam logic [7:0] HYST_MAX = 8'h80;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_CRANK, ST_POST, ST_WARM, ST_RUN, ST_STOP, ST_FAIL
  } gasr_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } gasr_apb_req_t;

  typedef struct packed {
    logic gen_stop_run_relay;
    logic starter_crank_relay;
    logic [2:0] aux_relay;
    logic gen_connect;
    logic error_led;
  } gasr_relays_t;

  typedef struct packed {
    logic on;
    logic [4:0] cnt;
  } gasr_aux_st_t;

  typedef struct packed {
    logic [1:0] mode;
    logic quiet;
    logic glow_fn;
    logic [11:0] lvl15;
    logic [11:0] low_battery_cutout_level;
    logic [7:0] exer_period;
    logic [10:0] maxrun;
    logic [7:0] warmup;
    logic [7:0] precrank;
    logic [3:0] crank;
    logic [7:0] postcrank;
    logic [2:0][11:0] trip;
    logic [2:0][7:0] hyst;
    logic [31:0] prdata;
    logic pslverr;
    logic [19:0] tenth_cnt;
    logic [3:0] tenth_in_sec;
    logic [1:0] sy1;
    logic [1:0] sy2;
    logic [1:0] sy3;
    logic [1:0] filt;
    gasr_state_t state;
    logic [7:0] secs;
    logic [2:0] attempts;
    logic [9:0] t15;
    logic [4:0] t30;
    logic vstart;
    logic [7:0] days;
    logic exer_active;
    logic [9:0] exer_secs;
    logic [8:0] qual_secs;
    logic [5:0] run_sec;
    logic [10:0] run_min;
    logic maxrun_err;
    logic flash;
    logic run_relay;
    logic crank_relay;
    logic connect;
  } gasr_top_st_t;

endpackage

// ### rtl/gasr_aux_relay.sv
module gasr_aux_relay
  import gasr_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tenth,
  input wire logic [11:0] batt_comp,
  input wire logic [11:0] trip,
  input wire logic [7:0] hyst,
  output logic energized
);

  gasr_aux_st_t st;
  gasr_aux_st_t next_st;
  logic above;
  logic low;

  // Compare in 13 bits so trip minus hysteresis cannot wrap below zero
  assign above = batt_comp > trip;
  assign low = ({1'b0, batt_comp} + {5'h00, hyst}) <= {1'b0, trip};

  // Energize at once; release only after the low level holds for 2 s
  always_comb
  begin
    next_st = st;
    if (above)
    begin
      next_st.on = 1'b1;
      next_st.cnt = 5'h00;
    end
    else if (st.on && low)
    begin
      if (tenth)
      begin
        if (st.cnt == AUX_REL_CNT - 5'h01)
        begin
          next_st.on = 1'b0;
          next_st.cnt = 5'h00;
        end
        else
        begin
          next_st.cnt = st.cnt + 5'h01;
        end
      end
    end
    else
    begin
      next_st.cnt = 5'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign energized = st.on;

  sequence s_release_due;
    st.on && low && !above && tenth && st.cnt == AUX_REL_CNT - 5'h01;
  endsequence

  AST_AUX_ENERGIZE: assert property (@(posedge pclk) disable iff (!presetn)
    above |=> st.on) else $error("aux relay did not energize");
  AST_AUX_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
    s_release_due |=> !st.on) else $error("aux relay did not release");
  AST_AUX_STAYS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (!st.on && !above) |=> !st.on) else $error("aux relay closed early");
  AST_AUX_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    (st.on && !low) |=> st.on) else $error("aux relay dropped above band");

endmodule

// ### rtl/gasr_top.sv
module gasr_top
  import gasr_pkg::*;
#(
  parameter int unsigned TENTH_CYC = CLK_HZ / TENTHS_PER_SEC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire gasr_apb_req_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] batt_raw,
  input wire logic [11:0] batt_comp,
  input wire logic gen_ac_pin,
  input wire logic utility_input,
  input wire logic end_quiet_strobe,
  output gasr_relays_t relays
);

  localparam logic [19:0] TENTH_LAST_CYC = 20'(TENTH_CYC - 1);

  gasr_top_st_t st;
  gasr_top_st_t next_st;
  logic [2:0] aux_on;
  logic setup;
  logic wr;
  logic tenth;
  logic sec;
  logic gen_ok;
  logic util_ok;
  logic autom;
  logic low15;
  logic low30;
  logic run_req;
  logic in_run;

  assign setup = apb.psel && !apb.penable;
  assign wr = apb.psel && apb.penable && apb.pwrite;
  assign tenth = st.tenth_cnt == TENTH_LAST_CYC;
  assign sec = tenth && st.tenth_in_sec == TENTH_LAST;
  assign gen_ok = st.filt[0];
  assign util_ok = st.filt[1];
  assign autom = st.mode == MODE_AUTO;
  assign low15 = batt_raw < st.lvl15;
  assign low30 = batt_raw < st.low_battery_cutout_level;
  assign in_run = st.state == ST_WARM || st.state == ST_RUN;
  assign run_req = st.mode == MODE_ON || (autom && (st.vstart || st.exer_active));

  // Relay loads are independent of inverter state; one comparator each
  for (genvar i = 0; i < 3; i++)
  begin : g_aux
    gasr_aux_relay u_aux (
      .pclk(pclk),
      .presetn(presetn),
      .tenth(tenth),
      .batt_comp(batt_comp),
      .trip(st.trip[i]),
      .hyst(st.hyst[i]),
      .energized(aux_on[i])
    );
  end

  always_comb
  begin
    logic [31:0] rdata;
    logic hit;
    logic ro;
    logic set15;
    logic set30;
    logic err_set;
    logic err_clr;
    logic rel;
    rdata = 32'h0000_0000;
    hit = 1'b1;
    ro = 1'b0;
    err_clr = 1'b0;
    rel = 1'b0;
    next_st = st;

    // Register read mux, latched in the setup phase so data comes from flops
    case (apb.paddr)
      A_CTRL: rdata = {28'h0000000, st.glow_fn, st.quiet, st.mode};
      A_LVL15: rdata = {20'h00000, st.lvl15};
      A_LOW_BATTERY_CUTOUT_LEVEL: rdata = {20'h00000, st.low_battery_cutout_level};
      A_LVL30:
      begin
        rdata = {20'h00000, st.low_battery_cutout_level};
        ro = 1'b1;
      end
      A_EXER: rdata = {24'h000000, st.exer_period};
      A_MAXRUN: rdata = {21'h000000, st.maxrun};
      A_WARMUP: rdata = {24'h000000, st.warmup};
      A_PRECRANK: rdata = {24'h000000, st.precrank};
      A_CRANK: rdata = {28'h0000000, st.crank};
      A_POSTCRANK: rdata = {24'h000000, st.postcrank};
      A_STATUS:
      begin
        rdata = {8'h00, st.days, st.vstart, st.exer_active, aux_on,
                 st.connect, util_ok, gen_ok, st.maxrun_err, st.attempts,
                 1'b0, st.state};
        ro = 1'b1;
      end
      default:
      begin
        hit = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
          if (apb.paddr == A_AUX_BASE + 8'(i) * A_AUX_STRIDE)
          begin
            rdata = {20'h00000, st.trip[i]};
            hit = 1'b1;
          end
          if (apb.paddr == A_AUX_BASE + 8'(i) * A_AUX_STRIDE + A_HYST_OFS)
          begin
            rdata = {24'h000000, st.hyst[i]};
            hit = 1'b1;
          end
        end
      end
    endcase
    if (setup)
    begin
      next_st.prdata = apb.pwrite ? 32'h0000_0000 : rdata;
      next_st.pslverr = !hit || (apb.pwrite && ro);
    end

    // Register writes take effect at the access edge; max run, warm up and hysteresis are clamped
    if (wr && !st.pslverr)
    begin
      case (apb.paddr)
        A_CTRL:
        begin
          next_st.mode = apb.pwdata[F_MODE +: 2];
          next_st.quiet = apb.pwdata[F_QUIET];
          next_st.glow_fn = apb.pwdata[F_GLOW];
          rel = apb.pwdata[F_RELEASE];
          err_clr = st.mode == MODE_OFF && apb.pwdata[F_MODE +: 2] != MODE_OFF;
        end
        A_LVL15: next_st.lvl15 = apb.pwdata[11:0];
        A_LOW_BATTERY_CUTOUT_LEVEL: next_st.low_battery_cutout_level = apb.pwdata[11:0];
        A_EXER: next_st.exer_period = apb.pwdata[7:0];
        A_MAXRUN: next_st.maxrun = apb.pwdata[10:0] > MAXRUN_MAX ? MAXRUN_MAX
                                   : apb.pwdata[10:0];
        A_WARMUP: next_st.warmup = apb.pwdata[7:0] < WARMUP_MIN ? WARMUP_MIN
                                   : apb.pwdata[7:0];
        A_PRECRANK: next_st.precrank = apb.pwdata[7:0];
        A_CRANK: next_st.crank = apb.pwdata[3:0];
        A_POSTCRANK: next_st.postcrank = apb.pwdata[7:0];
        default:
        begin
          for (int i = 0; i < 3; i++)
          begin
            if (apb.paddr == A_AUX_BASE + 8'(i) * A_AUX_STRIDE)
              next_st.trip[i] = apb.pwdata[11:0];
            if (apb.paddr == A_AUX_BASE + 8'(i) * A_AUX_STRIDE + A_HYST_OFS)
              next_st.hyst[i] = apb.pwdata[7:0] < HYST_MIN ? HYST_MIN
                : (apb.pwdata[7:0] > HYST_MAX ? HYST_MAX : apb.pwdata[7:0]);
          end
        end
      endcase
    end

    // Tenth and second enables from one divider
    next_st.tenth_cnt = tenth ? 20'h00000 : st.tenth_cnt + 20'h00001;
    if (tenth)
      next_st.tenth_in_sec = sec ? 4'h0 : st.tenth_in_sec + 4'h1;

    // Pin filter: a change counts once the last two stages agree
    next_st.sy1 = {utility_input, gen_ac_pin};
    next_st.sy2 = st.sy1;
    next_st.sy3 = st.sy2;
    for (int b = 0; b < 2; b++)
    begin
      if (st.sy2[b] == st.sy3[b])
        next_st.filt[b] = st.sy3[b];
    end

    // Continuous low-voltage timers; any lapse restarts them
    set15 = sec && low15 && !st.quiet && st.t15 == T15_CNT - 10'h001;
    set30 = sec && low30 && st.t30 == T30_CNT - 5'h01;
    if (!low15 || st.quiet)
      next_st.t15 = 10'h000;
    else if (sec && st.t15 != T15_CNT)
      next_st.t15 = st.t15 + 10'h001;
    if (!low30)
      next_st.t30 = 5'h00;
    else if (sec && st.t30 != T30_CNT)
      next_st.t30 = st.t30 + 5'h01;
    // Start request latch; a new trigger beats a release in the same cycle
    if (autom && (set15 || set30))
      next_st.vstart = 1'b1;
    else if (!autom || rel)
      next_st.vstart = 1'b0;

    // Exercise day count, advanced at each end of quiet time while the period is nonzero
    if (end_quiet_strobe && st.exer_period != 8'h00)
    begin
      if (st.days + 8'h01 >= st.exer_period)
      begin
        next_st.days = 8'h00;
        if (autom)
        begin
          next_st.exer_active = 1'b1;
          next_st.exer_secs = 10'h000;
        end
      end
      else
      begin
        next_st.days = st.days + 8'h01;
      end
    end
    if (st.exer_active && sec)
    begin
      next_st.exer_secs = st.exer_secs + 10'h001;
      if (st.exer_secs == EXER_RUN_CNT - 10'h001)
        next_st.exer_active = 1'b0;
    end
    if (!autom)
      next_st.exer_active = 1'b0;
    // A qualifying run of any origin restarts the period
    if (!(in_run && gen_ok))
      next_st.qual_secs = 9'h000;
    else if (sec && st.qual_secs != EXER_QUAL_CNT)
    begin
      next_st.qual_secs = st.qual_secs + 9'h001;
      if (st.qual_secs == EXER_QUAL_CNT - 9'h001)
        next_st.days = 8'h00;
    end

    // Start sequence; secs restarts on each state change except into ST_RUN or ST_IDLE
    if (sec && st.secs != 8'hff)
      next_st.secs = st.secs + 8'h01;
    case (st.state)
      ST_IDLE:
      begin
        next_st.attempts = 3'h0;
        if (run_req)
        begin
          next_st.state = ST_PRE;
          next_st.secs = 8'h00;
          next_st.attempts = 3'h1;
        end
      end
      ST_PRE:
      begin
        if (!run_req)
        begin
          next_st.state = ST_STOP;
          next_st.secs = 8'h00;
        end
        else if (st.secs >= st.precrank)
        begin
          next_st.state = ST_CRANK;
          next_st.secs = 8'h00;
        end
      end
      ST_CRANK:
      begin
        if (gen_ok || st.secs >= {4'h0, st.crank} || !run_req)
        begin
          next_st.state = ST_POST;
          next_st.secs = 8'h00;
        end
      end
      ST_POST:
      begin
        if (!run_req)
        begin
          next_st.state = ST_STOP;
          next_st.secs = 8'h00;
        end
        else if (st.secs >= st.postcrank)
        begin
          next_st.secs = 8'h00;
          if (gen_ok)
            next_st.state = ST_WARM;
          else if (st.attempts == MAX_ATTEMPTS)
            next_st.state = ST_FAIL;
          else
          begin
            next_st.state = ST_PRE;
            next_st.attempts = st.attempts + 3'h1;
          end
        end
      end
      ST_WARM:
      begin
        if (!run_req)
        begin
          next_st.state = ST_STOP;
          next_st.secs = 8'h00;
        end
        else if (st.secs >= st.warmup)
          next_st.state = ST_RUN;
      end
      ST_RUN:
      begin
        if (!run_req)
        begin
          next_st.state = ST_STOP;
          next_st.secs = 8'h00;
        end
      end
      ST_STOP:
      begin
        if (st.secs >= STOP_PULSE_CNT)
          next_st.state = ST_IDLE;
      end
      ST_FAIL:
      begin
        if (st.mode == MODE_OFF)
          next_st.state = ST_IDLE;
      end
      default: next_st.state = ST_IDLE;
    endcase

    // Run time since start; the error is only advisory and never stops it
    if (!in_run)
    begin
      next_st.run_sec = 6'h00;
      next_st.run_min = 11'h000;
    end
    else if (sec)
    begin
      next_st.run_sec = st.run_sec == SEC_LAST ? 6'h00 : st.run_sec + 6'h01;
      if (st.run_sec == SEC_LAST && st.run_min != 11'h7ff)
        next_st.run_min = st.run_min + 11'h001;
    end
    err_set = in_run && st.maxrun != 11'h000 && st.run_min >= st.maxrun;
    next_st.maxrun_err = err_set || (st.maxrun_err && !err_clr);
    if (!st.maxrun_err)
      next_st.flash = 1'b0;
    else if (sec)
      next_st.flash = !st.flash;

    // Relay drive follows the next state so outputs match the state flops
    next_st.crank_relay = next_st.state == ST_CRANK;
    if (next_st.glow_fn)
      next_st.run_relay = next_st.state == ST_PRE
                          || next_st.state == ST_STOP;
    else
      next_st.run_relay = next_st.state inside {ST_PRE, ST_CRANK, ST_POST,
                                                ST_WARM, ST_RUN};
    next_st.connect = next_st.state == ST_RUN
                      && !(next_st.exer_active && next_st.filt[1]);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.mode <= MODE_RST;
      st.lvl15 <= LVL15_RST;
      st.low_battery_cutout_level <= LOW_BATTERY_CUTOUT_LEVEL_RST;
      st.exer_period <= EXER_RST;
      st.maxrun <= MAXRUN_RST;
      st.warmup <= WARMUP_RST;
      st.precrank <= PRECRANK_RST;
      st.crank <= CRANK_RST;
      st.postcrank <= POSTCRANK_RST;
      st.trip <= TRIP_RST;
      st.hyst <= {3{HYST_RST}};
      st.state <= ST_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Zero-wait slave; error only shown in the access phase
  assign pready = 1'b1;
  assign pslverr = apb.psel && apb.penable && st.pslverr;
  assign prdata = st.prdata;
  assign relays = '{gen_stop_run_relay: st.run_relay,
                    starter_crank_relay: st.crank_relay, aux_relay: aux_on,
                    gen_connect: st.connect, error_led: st.flash};

  sequence s_post_done_fail;
    st.state == ST_POST && run_req && st.secs >= st.postcrank && !gen_ok;
  endsequence

  AST_QUIET_BLOCKS_15M: assert property (@(posedge pclk) disable iff (!presetn)
    st.quiet |=> st.t15 == 10'h000) else $error("15 min timer ran in quiet");
  AST_30S_START: assert property (@(posedge pclk) disable iff (!presetn)
    (autom && sec && low30 && st.t30 == T30_CNT - 5'h01) |=> st.vstart)
    else $error("30 s trigger missed");
  AST_30S_MIRROR: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !apb.pwrite && apb.paddr == A_LVL30) |=> st.prdata[11:0] == st.low_battery_cutout_level)
    else $error("30 s level differs from cutout");
  AST_EXER_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    (st.exer_period == 8'h00 && !st.exer_active) |=> !st.exer_active)
    else $error("exercise began with period zero");
  AST_NO_UTIL_CONNECT: assert property (@(posedge pclk) disable iff (!presetn)
    st.connect |-> !(st.exer_active && util_ok))
    else $error("generator connected during exercise on utility");
  AST_MAXRUN_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
    (run_req && in_run && st.maxrun != 11'h000 && st.run_min >= st.maxrun)
    |=> st.maxrun_err && st.state != ST_STOP)
    else $error("run time error missing or generator stopped");
  AST_ERR_STICKS: assert property (@(posedge pclk) disable iff (!presetn)
    (st.maxrun_err && st.mode != MODE_OFF) |=> st.maxrun_err)
    else $error("run time error cleared without off");
  AST_RUN_FUNC: assert property (@(posedge pclk) disable iff (!presetn)
    !st.glow_fn |-> st.run_relay == (st.state inside {ST_PRE, ST_CRANK,
    ST_POST, ST_WARM, ST_RUN})) else $error("run relay wrong");
  AST_GLOW_FUNC: assert property (@(posedge pclk) disable iff (!presetn)
    st.glow_fn |-> st.run_relay == (st.state == ST_PRE || st.state == ST_STOP))
    else $error("glow/stop relay wrong");
  AST_CRANK_LIMIT: assert property (@(posedge pclk) disable iff (!presetn)
    st.crank_relay |-> st.state == ST_CRANK && st.secs <= {4'h0, st.crank})
    else $error("starter held past limit");
  AST_RETRY: assert property (@(posedge pclk) disable iff (!presetn)
    s_post_done_fail |=> (st.state == ST_FAIL) == ($past(st.attempts) == 3'h5))
    else $error("retry count wrong");

endmodule

// ### tb/gasr_gen_model.sv
module gasr_gen_model (
  input wire logic pclk,
  input wire logic stop,
  input wire logic crank,
  output logic gen_ac
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt = 8'h00;
  initial gen_ac = 1'b0;
  // Engine fires after 50 crank cycles; a stop command outside cranking
  // kills it, so a stuck stop relay shows up as a dead generator
  always @(posedge pclk)
  begin
    cnt <= crank ? cnt + 8'h01 : 8'h00;
    gen_ac <= (gen_ac || cnt == 8'h32) && !(stop && !crank);
  end
endmodule

// ### tb/gasr_top_test.sv
module gasr_top_test;
  import gasr_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic glow = 1'b0;
  logic gen_ac, pready, pslverr;
  logic [31:0] prdata, rd;
  logic [11:0] batt_raw = 12'h0c8;
  logic [11:0] batt_comp = 12'h080;
  logic util_in = 1'b0;
  logic quiet_end = 1'b0;
  gasr_apb_req_t apb = '0;
  gasr_relays_t relays;
  int fails = 0;
  int total_checks = 0;
  int n;
  always #50 pclk = ~pclk;
  // A second is 100 cycles so the long sequences fit the run
  gasr_top #(.TENTH_CYC(10)) uut (.pclk(pclk), .presetn(presetn),
    .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .batt_raw(batt_raw), .batt_comp(batt_comp), .gen_ac_pin(gen_ac),
    .utility_input(util_in), .end_quiet_strobe(quiet_end),
    .relays(relays));
  gasr_gen_model gen (.pclk(pclk), .crank(relays.starter_crank_relay),
    .stop(glow ~^ relays.gen_stop_run_relay), .gen_ac(gen_ac));
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen high at an access edge
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic err);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    apb.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, err});
    apb <= '0;
    @(posedge pclk);
  endtask
  task automatic regs_t();
    xfer(1'b1, A_WARMUP, 32'h08, 1'b0);
    xfer(1'b0, A_WARMUP, 32'h0, 1'b0);
    chk(rd, 32'h10);
    xfer(1'b1, A_LOW_BATTERY_CUTOUT_LEVEL, 32'h70, 1'b0);
    xfer(1'b0, A_LVL30, 32'h0, 1'b0);
    chk(rd, 32'h70);
    xfer(1'b1, A_LVL30, 32'h55, 1'b1);
    xfer(1'b0, 8'h44, 32'h0, 1'b1);
    xfer(1'b1, A_PRECRANK, 32'h1, 1'b0);
    xfer(1'b1, A_CRANK, 32'h2, 1'b0);
    xfer(1'b1, A_POSTCRANK, 32'h1, 1'b0);
  endtask
  // Full start, run and stop with either relay function
  task automatic gen_run(input logic g);
    glow <= g;
    xfer(1'b1, A_CTRL, {28'h0, g, 1'b0, MODE_ON}, 1'b0);
    repeat (3) @(posedge pclk);
    chk(relays.gen_stop_run_relay, 1'b1);
    for (n = 0; n < 200 && !relays.starter_crank_relay; n++)
      @(posedge pclk);
    chk(n <= 105, 1'b1);
    repeat (1500) @(posedge pclk);
    chk(relays.gen_connect, 1'b0);
    for (n = 0; n < 400 && !relays.gen_connect; n++)
      @(posedge pclk);
    chk(n < 400, 1'b1);
    chk(relays.gen_stop_run_relay, !g);
    xfer(1'b1, A_CTRL, {28'h0, g, 1'b0, MODE_OFF}, 1'b0);
    repeat (3) @(posedge pclk);
    chk(relays.gen_stop_run_relay, g);
    repeat (400) @(posedge pclk);
  endtask
  // Zero crank time never starts the engine: five tries, then a lockout
  task automatic fail_t();
    xfer(1'b1, A_CRANK, 32'h0, 1'b0);
    xfer(1'b1, A_CTRL, 32'h2, 1'b0);
    repeat (1100) @(posedge pclk);
    xfer(1'b0, A_STATUS, 32'h0, 1'b0);
    chk(rd & 32'h7f, 32'h57);
    chk(relays.gen_stop_run_relay, 1'b0);
    xfer(1'b1, A_CTRL, 32'h0, 1'b0);
    xfer(1'b1, A_CRANK, 32'h2, 1'b0);
  endtask
  task automatic aux_t();
    batt_comp <= 12'h095;
    repeat (3) @(posedge pclk);
    chk(relays.aux_relay, 3'b011);
    batt_comp <= 12'h087;
    repeat (150) @(posedge pclk);
    chk(relays.aux_relay, 3'b011);
    repeat (60) @(posedge pclk);
    chk(relays.aux_relay, 3'b000);
  endtask
  // Low battery in auto mode with quiet time still starts in 30 s
  task automatic vstart_t();
    glow <= 1'b0;
    batt_raw <= 12'h06d;
    xfer(1'b1, A_CTRL, 32'h05, 1'b0);
    repeat (2800) @(posedge pclk);
    chk(relays.gen_stop_run_relay, 1'b0);
    for (n = 0; n < 300 && !relays.gen_stop_run_relay; n++)
      @(posedge pclk);
    chk(n < 300, 1'b1);
  endtask
  // Exercise start in auto mode; utility power keeps the load off, and a
  // one-minute run limit raises the advisory error without a stop
  task automatic exer_t();
    logic led;
    util_in <= 1'b1;
    batt_raw <= 12'h0c8;
    xfer(1'b1, A_MAXRUN, 32'h1, 1'b0);
    xfer(1'b1, A_EXER, 32'h0, 1'b0);
    xfer(1'b1, A_CTRL, 32'h11, 1'b0);
    repeat (400) @(posedge pclk);
    for (n = 0; n < 2; n++)
    begin
      quiet_end <= 1'b1;
      @(posedge pclk);
      quiet_end <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(relays.gen_stop_run_relay, n);
      xfer(1'b1, A_EXER, 32'h1, 1'b0);
    end
    repeat (2000) @(posedge pclk);
    xfer(1'b0, A_STATUS, 32'h0, 1'b0);
    chk(rd & 32'h407, 32'h005);
    util_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(relays.gen_connect, 1'b1);
    repeat (4500) @(posedge pclk);
    xfer(1'b0, A_STATUS, 32'h0, 1'b0);
    chk(rd & 32'h87, 32'h85);
    led = relays.error_led;
    repeat (100) @(posedge pclk);
    chk(relays.error_led, !led);
    xfer(1'b1, A_CTRL, 32'h1, 1'b0);
    xfer(1'b0, A_STATUS, 32'h0, 1'b0);
    chk(rd & 32'h80, 32'h80);
    xfer(1'b1, A_CTRL, 32'h0, 1'b0);
    xfer(1'b1, A_CTRL, 32'h1, 1'b0);
    xfer(1'b0, A_STATUS, 32'h0, 1'b0);
    chk(rd & 32'h80, 32'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    regs_t();
    gen_run(1'b0);
    fail_t();
    gen_run(1'b1);
    aux_t();
    vstart_t();
    exer_t();
    summarize();
  end
  // Watchdog well beyond the expected 15800 cycles
  initial
  begin
    repeat (30000) @(posedge pclk);
    fails++;
    summarize();
  end
endmodule
